// file: hdl/flsr_pkg.sv
// Package with register map, field positions and reset values for the LED status registers
package flsr_pkg;
	localparam logic [7:0] FLSR_ADDR_FAULT = 8'h17;
	localparam logic [7:0] FLSR_ADDR_LIGHT = 8'h18;
	localparam logic [7:0] FLSR_ADDR_FLCUR = 8'h19;
	localparam int FLSR_BIT_SUPPLY_UNDERVOLTAGE_LOCKOUT = 7;
	localparam int FLSR_BIT_SECOND_LED_OPEN_FAULT = 6;
	localparam int FLSR_BIT_SECOND_LED_SHORT_FAULT = 5;
	localparam int FLSR_BIT_FIRST_LED_OPEN_FAULT = 4;
	localparam int FLSR_BIT_FIRST_LED_SHORT_FAULT = 3;
	localparam int FLSR_BIT_BATLOW = 2;
	localparam int FLSR_BIT_CURLIM = 1;
	localparam int FLSR_BIT_OVERV = 0;
	localparam logic [7:0] FLSR_FAULT_RESET = 8'h00;
	localparam logic [3:0] FLSR_FLCUR_RESET = 4'h0;
	localparam logic [3:0] FLSR_FLCUR_OFF = 4'h0;
	localparam logic [3:0] FLSR_FLCUR_MIN = 4'h7;
	localparam int FLSR_FLCUR_BASE_MA = 350;
	localparam int FLSR_FLCUR_STEP_MA = 50;
	localparam int FLSR_OPEN_DERATE_MA = 50;
	localparam logic [9:0] FLSR_MA_ZERO = 10'h000;
endpackage : flsr_pkg

// file: hdl/flsr_sync_if.sv
// Interface carrying synchronised fault and status levels into the register bank
`timescale 1ns/1ps
interface flsr_sync_if;
	logic [7:0] fault_lvl;
	logic [7:0] light_lvl;
	modport src (output fault_lvl, output light_lvl);
	modport dst (input fault_lvl, input light_lvl);
endinterface : flsr_sync_if

// file: hdl/flsr_sync.sv
// Two-stage synchroniser for all asynchronous status inputs
`timescale 1ns/1ps
module flsr_sync (
	input wire logic mclk,
	input wire logic arst_n,
	input wire logic [7:0] fault_in,
	input wire logic [7:0] light_in,
	flsr_sync_if.src sy
);
	logic [15:0] stage1_reg;
	logic [15:0] stage2_reg;
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			stage1_reg <= 16'h0000;
			stage2_reg <= 16'h0000;
		end else begin
			stage1_reg <= {fault_in, light_in};
			stage2_reg <= stage1_reg;
		end
	end
	assign sy.fault_lvl = stage2_reg[15:8];
	assign sy.light_lvl = stage2_reg[7:0];
endmodule : flsr_sync

// file: hdl/flsr_regs.sv
// Flash LED fault, lighting status and flash current register bank
`timescale 1ns/1ps
module flsr_regs (
	input wire logic mclk,
	input wire logic arst_n,
	input wire logic [7:0] reg_addr,
	input wire logic reg_rd,
	input wire logic reg_wr,
	input wire logic [7:0] reg_wdata,
	output logic [7:0] reg_rdata,
	input wire logic supply_undervoltage_lockout,
	input wire logic second_led_open_fault,
	input wire logic second_led_short_fault,
	input wire logic first_led_open_fault,
	input wire logic first_led_short_fault,
	input wire logic battery_below_threshold,
	input wire logic boost_current_limit_flag,
	input wire logic boost_overvoltage_flag,
	input wire logic first_led_flash_active,
	input wire logic second_led_flash_active,
	input wire logic first_led_movie_active,
	input wire logic second_led_movie_active,
	input wire logic flash_trigger_pin,
	input wire logic flash_inhibit_pin,
	input wire logic second_led_disabled,
	input wire logic flash_timer_running,
	output logic shutdown,
	output logic [3:0] flash_current_code,
	output logic [9:0] first_led_ma,
	output logic [9:0] second_led_ma
);
	import flsr_pkg::*;

	flsr_sync_if sy ();

	logic [7:0] fault_reg;
	logic [7:0] fault_next;
	logic [7:0] light_reg;
	logic [3:0] flcur_reg;
	logic [7:0] rdata_next;
	logic [9:0] base_ma;
	logic [9:0] led1_ma_next;
	logic [9:0] led2_ma_next;
	logic flash_on;
	logic batlow_pend_reg;

	flsr_sync u_sync (
		.mclk(mclk),
		.arst_n(arst_n),
		.fault_in({supply_undervoltage_lockout, second_led_open_fault,
			second_led_short_fault, first_led_open_fault, first_led_short_fault,
			battery_below_threshold, boost_current_limit_flag, boost_overvoltage_flag}),
		.light_in({first_led_flash_active, second_led_flash_active,
			first_led_movie_active, second_led_movie_active, flash_trigger_pin,
			flash_inhibit_pin, second_led_disabled, flash_timer_running}),
		.sy(sy.src)
	);

	wire sel_fault = reg_addr == FLSR_ADDR_FAULT;
	wire sel_light = reg_addr == FLSR_ADDR_LIGHT;
	wire sel_flcur = reg_addr == FLSR_ADDR_FLCUR;
	wire rd_fault = reg_rd && sel_fault;
	// Writes to the status registers are ignored
	wire wr_flcur = reg_wr && sel_flcur;
	assign flash_on = sy.light_lvl[7] || sy.light_lvl[6];

	// Sticky set from live levels; a set arriving with a read-clear wins
	wire [7:0] set_mask = {sy.fault_lvl[7:3], 1'b0, sy.fault_lvl[1:0]};
	wire [7:0] kept = rd_fault ? 8'h00 : fault_reg;
	// Low battery is sampled only while flash current flows
	wire batlow_set = flash_on && sy.fault_lvl[FLSR_BIT_BATLOW];

	always_comb begin
		fault_next = (kept | set_mask);
		// A read between flashes only takes effect at the next flash
		fault_next[FLSR_BIT_BATLOW] = flash_on ? (batlow_set || (!batlow_pend_reg
			&& !rd_fault && fault_reg[FLSR_BIT_BATLOW])) : fault_reg[FLSR_BIT_BATLOW];
	end

	assign rdata_next = sel_fault ? fault_reg :
		sel_light ? light_reg :
		sel_flcur ? {4'h0, flcur_reg} : 8'h00;

	// Current in mA from code; reserved codes read as off in the drive path
	assign base_ma = (flcur_reg >= FLSR_FLCUR_MIN) ?
		10'(FLSR_FLCUR_BASE_MA + FLSR_FLCUR_STEP_MA * int'(flcur_reg - FLSR_FLCUR_MIN))
		: FLSR_MA_ZERO;
	wire [9:0] derated_ma = (base_ma > 10'(FLSR_OPEN_DERATE_MA)) ?
		10'(base_ma - 10'(FLSR_OPEN_DERATE_MA)) : FLSR_MA_ZERO;
	wire open1 = sy.fault_lvl[FLSR_BIT_FIRST_LED_OPEN_FAULT];
	wire open2 = sy.fault_lvl[FLSR_BIT_SECOND_LED_OPEN_FAULT];
	assign led1_ma_next = open1 ? FLSR_MA_ZERO : (open2 ? derated_ma : base_ma);
	assign led2_ma_next = open2 ? FLSR_MA_ZERO : (open1 ? derated_ma : base_ma);

	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			fault_reg <= FLSR_FAULT_RESET;
			batlow_pend_reg <= 1'b0;
		end else begin
			fault_reg <= fault_next;
			// Remember a read-clear pending until the next flash
			batlow_pend_reg <= flash_on ? 1'b0 : (batlow_pend_reg || rd_fault);
		end
	end

	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			light_reg <= 8'h00;
			flcur_reg <= FLSR_FLCUR_RESET;
		end else begin
			light_reg <= sy.light_lvl;
			if (wr_flcur) begin
				flcur_reg <= reg_wdata[3:0];
			end
		end
	end

	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			reg_rdata <= 8'h00;
			shutdown <= 1'b0;
			flash_current_code <= FLSR_FLCUR_RESET;
			first_led_ma <= FLSR_MA_ZERO;
			second_led_ma <= FLSR_MA_ZERO;
		end else begin
			if (reg_rd) begin
				reg_rdata <= rdata_next;
			end
			shutdown <= sy.fault_lvl[FLSR_BIT_SUPPLY_UNDERVOLTAGE_LOCKOUT];
			flash_current_code <= flcur_reg;
			first_led_ma <= led1_ma_next;
			second_led_ma <= led2_ma_next;
		end
	end
endmodule : flsr_regs

// file: test/flsr_regs_properties.sv
// Checker for the LED status register bank
`timescale 1ns/1ps
module flsr_regs_properties import flsr_pkg::*; (
	input wire logic mclk,
	input wire logic arst_n,
	input wire logic reg_rd,
	input wire logic reg_wr,
	input wire logic shutdown,
	input wire logic flash_trigger_pin,
	input wire logic supply_undervoltage_lockout,
	input wire logic first_led_open_fault,
	input wire logic second_led_open_fault,
	input wire logic boost_overvoltage_flag,
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic [7:0] reg_rdata,
	input wire logic [3:0] flash_current_code,
	input wire logic [9:0] first_led_ma,
	input wire logic [9:0] second_led_ma
);
	default clocking @(posedge mclk); endclocking
	default disable iff (!arst_n);
	wire rf = reg_rd && reg_addr == FLSR_ADDR_FAULT;
	wire wc = reg_wr && reg_addr == FLSR_ADDR_FLCUR;
	property p_uv; supply_undervoltage_lockout[*5] |-> shutdown; endproperty
	a_uv: assert property (p_uv) else $error("no shutdown");
	property p_open; second_led_open_fault[*5] ##0 rf |=> reg_rdata[6]; endproperty
	a_open: assert property (p_open) else $error("open flag lost");
	// Two cycles apart so the second read sees a settled clear
	property p_clr; (!boost_overvoltage_flag)[*4] ##0 rf ##2 rf |=> !reg_rdata[0]; endproperty
	a_clr: assert property (p_clr) else $error("flag not cleared");
	property p_wr; wc |-> ##2 {4'h0, flash_current_code} == ($past(reg_wdata, 2) & 8'h0F); endproperty
	a_wr: assert property (p_wr) else $error("code not stored");
	property p_off; flash_current_code < FLSR_FLCUR_MIN |-> first_led_ma == FLSR_MA_ZERO
		&& second_led_ma == FLSR_MA_ZERO; endproperty
	a_off: assert property (p_off) else $error("drive while off");
	property p_own; first_led_open_fault[*5] |-> first_led_ma == FLSR_MA_ZERO; endproperty
	a_own: assert property (p_own) else $error("open led driven");
	property p_own2; second_led_open_fault[*5] |-> second_led_ma == FLSR_MA_ZERO; endproperty
	a_own2: assert property (p_own2) else $error("open second led driven");
	property p_der; (second_led_open_fault && !first_led_open_fault
		&& flash_current_code == 4'hF)[*5] |-> first_led_ma == 10'h2BC; endproperty
	a_der: assert property (p_der) else $error("no derating");
	property p_trig; flash_trigger_pin[*6] ##0 (reg_rd && reg_addr == FLSR_ADDR_LIGHT)
		|=> reg_rdata[3]; endproperty
	a_trig: assert property (p_trig) else $error("trigger mirror wrong");
	c_rf: cover property (rf);
	c_wc: cover property (wc);
	c_sd: cover property (shutdown);
endmodule : flsr_regs_properties
bind flsr_regs flsr_regs_properties u_props (.*);

// file: test/flsr_host.sv
// Host model issuing single register accesses
`timescale 1ns/1ps
module flsr_host (
	input wire logic mclk,
	output logic [7:0] reg_addr,
	output logic reg_rd,
	output logic reg_wr,
	output logic [7:0] reg_wdata
);
	initial {reg_addr, reg_rd, reg_wr, reg_wdata} = 18'h0;
	task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] d);
		@(negedge mclk);
		{reg_addr, reg_rd, reg_wr, reg_wdata} = {a, !w, w, d};
		@(negedge mclk);
		{reg_rd, reg_wr} = 2'h0;
		reg_wdata = ~d;
	endtask : acc
endmodule : flsr_host

// file: test/tb_flsr_regs.sv
// Self-checking bench for the LED status register bank
`timescale 1ns/1ps
module tb_flsr_regs;
	import flsr_pkg::*;
	logic mclk = 0, arst_n = 0, rv = 0, reg_rd, reg_wr;
	logic [7:0] reg_addr, reg_wdata, reg_rdata, e, v, f = 8'h00, l = 8'h00;
	logic [7:0] exp_q[$];
	int failures = 0, cmp_count = 0, seed = 92260, i;
	always #10 mclk = ~mclk;
	flsr_host host_u (.*);
	flsr_regs dut_u (.*, .supply_undervoltage_lockout(f[7]), .second_led_open_fault(f[6]),
		.second_led_short_fault(f[5]), .first_led_open_fault(f[4]), .first_led_short_fault(f[3]),
		.battery_below_threshold(f[2]), .boost_current_limit_flag(f[1]),
		.boost_overvoltage_flag(f[0]), .first_led_flash_active(l[7]),
		.second_led_flash_active(l[6]), .first_led_movie_active(l[5]),
		.second_led_movie_active(l[4]), .flash_trigger_pin(l[3]), .flash_inhibit_pin(l[2]),
		.second_led_disabled(l[1]), .flash_timer_running(l[0]), .shutdown(),
		.flash_current_code(), .first_led_ma(), .second_led_ma());
	task automatic rd(input logic [7:0] a, input logic [7:0] x);
		exp_q.push_back(x);
		host_u.acc(1'b0, a, 8'h00);
	endtask : rd
	task automatic close_out;
		$display("compares %0d failures %0d", cmp_count, failures);
		if (failures == 0 && cmp_count > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask : close_out
	always @(posedge mclk) rv <= reg_rd;
	always @(negedge mclk) if (rv) begin
		e = exp_q.pop_front();
		cmp_count++;
		if (reg_rdata !== e) begin
			failures++;
			$display("[FAIL] t=%0t got %h exp %h", $time, reg_rdata, e);
		end
	end
	initial begin
		repeat (3000) @(posedge mclk);
		failures++;
		close_out();
	end
	initial begin
		repeat (16) @(negedge mclk);
		arst_n = 1;
		rd(FLSR_ADDR_FLCUR, 8'h00);
		rd(8'h20, 8'h00);
		host_u.acc(1'b1, FLSR_ADDR_FAULT, 8'hFF);
		rd(FLSR_ADDR_FAULT, 8'h00);
		// Reserved codes skipped, the host may not write them
		for (i = 0; i < 16; i++) if (i == 0 || i > 6) begin
			v = 8'($random(seed));
			host_u.acc(1'b1, FLSR_ADDR_FLCUR, {v[7:4], i[3:0]});
			rd(FLSR_ADDR_FLCUR, {4'h0, i[3:0]});
		end
		$display("current register test done");
		f = 8'h40;
		repeat (6) @(negedge mclk);
		rd(FLSR_ADDR_FAULT, 8'h40);
		f = 8'hFB;
		repeat (5) @(negedge mclk);
		rd(FLSR_ADDR_FAULT, 8'hFB);
		f = 8'h00;
		repeat (4) @(negedge mclk);
		rd(FLSR_ADDR_FAULT, 8'hFB);
		rd(FLSR_ADDR_FAULT, 8'h00);
		$display("fault test done");
		f = 8'h04;
		repeat (5) @(negedge mclk);
		rd(FLSR_ADDR_FAULT, 8'h00);
		l = 8'h80;
		repeat (5) @(negedge mclk);
		rd(FLSR_ADDR_FAULT, 8'h04);
		{f, l} = 16'h0000;
		repeat (5) @(negedge mclk);
		rd(FLSR_ADDR_FAULT, 8'h04);
		l = 8'h80;
		repeat (5) @(negedge mclk);
		rd(FLSR_ADDR_FAULT, 8'h00);
		$display("battery test done");
		for (i = 0; i < 8; i++) begin
			l = 8'($random(seed));
			repeat (6) @(negedge mclk);
			rd(FLSR_ADDR_LIGHT, l);
		end
		$display("lighting test done");
		repeat (4) @(negedge mclk);
		close_out();
	end
endmodule : tb_flsr_regs
